// [rtl/tplm_pkg.sv]
package tplm_pkg;

  // Configured and established link modes share one 3-bit encoding
  typedef enum logic [2:0] {
    TPLM_AUTO                 = 3'h0,
    TPLM_FULL_BANDWIDTH_MODE  = 3'h1,
    TPLM_LONG_REACH_MODE      = 3'h2,
    TPLM_LOW_POWER_SERIAL_ONLY_MODE     = 3'h3,
    TPLM_LOW_POWER_SERIAL_ETHERNET_MODE = 3'h4
  } tplm_mode_e;

  localparam int unsigned TPLM_MODE_W     = 3;
  localparam int unsigned TPLM_SERIAL_BAUD = 9600;
  localparam int unsigned TPLM_CLK_HZ     = 40_000_000;
  // Cycles per serial bit at the low-power serial rate
  localparam int unsigned TPLM_BAUD_DIV   = TPLM_CLK_HZ / TPLM_SERIAL_BAUD;
  localparam int unsigned TPLM_MAX_VIDEO_LINES_FULL  = 2160;
  localparam int unsigned TPLM_MAX_VIDEO_LINES_REACH = 1080;
  localparam int unsigned TPLM_MAX_VIDEO_HZ_REACH    = 60;

  // Joint resolution of both configured modes
  function automatic tplm_mode_e tplm_resolve(
    input tplm_mode_e tx_mode,
    input tplm_mode_e rx_mode,
    input logic       tx_video,
    input logic       lp_ethernet
  );
    tplm_mode_e res;
    res = TPLM_FULL_BANDWIDTH_MODE;
    if (tx_mode == TPLM_LOW_POWER_SERIAL_ONLY_MODE ||
        rx_mode == TPLM_LOW_POWER_SERIAL_ONLY_MODE) begin
      res = TPLM_LOW_POWER_SERIAL_ONLY_MODE;
    end else if (tx_mode == TPLM_LOW_POWER_SERIAL_ETHERNET_MODE ||
                 rx_mode == TPLM_LOW_POWER_SERIAL_ETHERNET_MODE) begin
      res = TPLM_LOW_POWER_SERIAL_ETHERNET_MODE;
    end else if (tx_mode == TPLM_LONG_REACH_MODE ||
                 rx_mode == TPLM_LONG_REACH_MODE) begin
      res = TPLM_LONG_REACH_MODE;
    end else if (tx_mode == TPLM_AUTO && rx_mode == TPLM_AUTO) begin
      // Both automatic: never long reach, video decides
      if (tx_video) begin
        res = TPLM_FULL_BANDWIDTH_MODE;
      end else if (lp_ethernet) begin
        res = TPLM_LOW_POWER_SERIAL_ETHERNET_MODE;
      end else begin
        res = TPLM_LOW_POWER_SERIAL_ONLY_MODE;
      end
    end
    return res;
  endfunction

  // Channel enables carried by the link for a given mode
  function automatic logic [3:0] tplm_channels(input tplm_mode_e m);
    logic [3:0] ch;
    ch = 4'h0;
    unique case (m)
      TPLM_FULL_BANDWIDTH_MODE,
      TPLM_LONG_REACH_MODE:                ch = 4'hF;
      TPLM_LOW_POWER_SERIAL_ETHERNET_MODE: ch = 4'h3;
      TPLM_LOW_POWER_SERIAL_ONLY_MODE:     ch = 4'h1;
      default:                             ch = 4'h0;
    endcase
    return ch;
  endfunction

  // Channel bit positions: serial, ethernet, audio, video
  localparam int unsigned TPLM_CH_SERIAL = 0;
  localparam int unsigned TPLM_CH_ETH    = 1;
  localparam int unsigned TPLM_CH_AUDIO  = 2;
  localparam int unsigned TPLM_CH_VIDEO  = 3;

endpackage

// [rtl/tplm_link_if.sv]
`timescale 1ns/1ps
// Negotiation link between transmitter and receiver controllers
interface tplm_link_if;
  import tplm_pkg::*;
  logic [2:0] tx_cfg;      // Transmitter configured mode
  logic       tx_video;    // Transmitter has valid video input
  logic       tx_lp_eth;   // Auto fallback prefers serial plus ethernet
  logic       prop_valid;  // Initiator proposes a mode
  logic [2:0] prop_mode;
  logic       rx_ack;      // Receiver accepts proposal
  logic [2:0] rx_cfg;      // Receiver configured mode
  logic       rx_prop_valid; // Receiver initiates (manual receiver)
  logic [2:0] rx_prop_mode;
  logic       tx_ack;

  modport tx_end (
    output tx_cfg, tx_video, tx_lp_eth, prop_valid, prop_mode, tx_ack,
    input  rx_ack, rx_cfg, rx_prop_valid, rx_prop_mode
  );
  modport rx_end (
    input  tx_cfg, tx_video, tx_lp_eth, prop_valid, prop_mode, tx_ack,
    output rx_ack, rx_cfg, rx_prop_valid, rx_prop_mode
  );
endinterface

// [rtl/tplm_rx.sv]
`timescale 1ns/1ps
module tplm_rx
  import tplm_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] cfg_mode_in,
  tplm_link_if.rx_end     link,
  output logic [2:0]      link_mode_out,
  output logic [3:0]      chan_en_out,
  output logic            busy_out
);

  typedef enum logic [1:0] {
    TPLM_IDLE   = 2'b00,
    TPLM_OFFER  = 2'b01,
    TPLM_FOLLOW = 2'b10
  } tplm_state_e;

  tplm_state_e state;
  tplm_mode_e  cfg;
  tplm_mode_e  target;
  tplm_mode_e  mode;
  logic        rx_manual;
  logic        tx_manual;

  // Illegal codes fall back to automatic
  always_comb begin
    if (cfg_mode_in <= 3'h4) begin
      cfg = tplm_mode_e'(cfg_mode_in);
    end else begin
      cfg = TPLM_AUTO;
    end
  end

  assign rx_manual = (cfg != TPLM_AUTO);
  assign tx_manual = (link.tx_cfg != 3'h0);
  // Joint resolution, recomputed every cycle from both settings
  assign target = tplm_resolve(tplm_mode_e'(link.tx_cfg),
                               cfg, link.tx_video,
                               link.tx_lp_eth);

  // Negotiation: receiver offers only when it alone is manual, otherwise it follows
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= TPLM_IDLE;
      mode  <= TPLM_LOW_POWER_SERIAL_ONLY_MODE;
    end else begin
      unique case (state)
        TPLM_IDLE: begin
          if (rx_manual && !tx_manual && target != mode) begin
            state <= TPLM_OFFER;
          end else if (link.prop_valid) begin
            state <= TPLM_FOLLOW;
          end
        end
        TPLM_OFFER: begin
          if (link.tx_ack) begin
            mode  <= tplm_mode_e'(link.rx_prop_mode);
            state <= TPLM_IDLE;
          end
        end
        TPLM_FOLLOW: begin
          mode  <= tplm_mode_e'(link.prop_mode);
          state <= TPLM_IDLE;
        end
        default: state <= TPLM_IDLE;
      endcase
    end
  end

  // Offer held until acknowledged; ack is a one-cycle pulse
  assign link.rx_prop_valid = (state == TPLM_OFFER);
  assign link.rx_prop_mode  = target;
  assign link.rx_ack        = (state == TPLM_FOLLOW);
  assign link.rx_cfg        = cfg;

  assign link_mode_out = mode;
  assign chan_en_out   = tplm_channels(mode);
  assign busy_out      = (state != TPLM_IDLE);

endmodule // tplm_rx

// [rtl/tplm_tx.sv]
`timescale 1ns/1ps
// Transmitter end: initiates unless the receiver alone is manual
module tplm_tx
  import tplm_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] cfg_mode_in,
  input  wire logic       video_in,
  input  wire logic       lp_eth_in,
  tplm_link_if.tx_end     link,
  output logic [2:0]      link_mode_out,
  output logic [3:0]      chan_en_out,
  output logic            busy_out
);

  typedef enum logic [1:0] {
    TPLM_T_IDLE  = 2'b00,
    TPLM_T_OFFER = 2'b01,
    TPLM_T_ACK   = 2'b10
  } tplm_tstate_e;

  tplm_tstate_e state;
  tplm_mode_e   cfg;
  tplm_mode_e   target;
  tplm_mode_e   mode;
  logic         video_s1;
  logic         video_s2;
  logic         rx_only_manual;

  always_comb begin
    if (cfg_mode_in <= 3'h4) begin
      cfg = tplm_mode_e'(cfg_mode_in);
    end else begin
      cfg = TPLM_AUTO;
    end
  end

  // Video presence is a pin, synchronised before use
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      video_s1 <= 1'b0;
      video_s2 <= 1'b0;
    end else begin
      video_s1 <= video_in;
      video_s2 <= video_s1;
    end
  end

  assign rx_only_manual = (cfg == TPLM_AUTO) && (link.rx_cfg != 3'h0);
  assign target = tplm_resolve(cfg, tplm_mode_e'(link.rx_cfg),
                               video_s2, lp_eth_in);

  // Propose on change, commit on acknowledge; follow a receiver that alone is manual
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= TPLM_T_IDLE;
      mode  <= TPLM_LOW_POWER_SERIAL_ONLY_MODE;
    end else begin
      unique case (state)
        TPLM_T_IDLE: begin
          if (rx_only_manual) begin
            if (link.rx_prop_valid) begin
              state <= TPLM_T_ACK;
            end
          end else if (target != mode) begin
            state <= TPLM_T_OFFER;
          end
        end
        TPLM_T_OFFER: begin
          if (link.rx_ack) begin
            mode  <= target;
            state <= TPLM_T_IDLE;
          end
        end
        TPLM_T_ACK: begin
          mode  <= tplm_mode_e'(link.rx_prop_mode);
          state <= TPLM_T_IDLE;
        end
        default: state <= TPLM_T_IDLE;
      endcase
    end
  end

  assign link.tx_cfg     = cfg;
  assign link.tx_video   = video_s2;
  assign link.tx_lp_eth  = lp_eth_in;
  assign link.prop_valid = (state == TPLM_T_OFFER);
  assign link.prop_mode  = target;
  assign link.tx_ack     = (state == TPLM_T_ACK);

  assign link_mode_out = mode;
  assign chan_en_out   = tplm_channels(mode);
  assign busy_out      = (state != TPLM_T_IDLE);

endmodule // tplm_tx

// [sim/tplm_link_properties.sv]
`timescale 1ns/1ps
// Watches the negotiation wires between the two ends
module tplm_link_properties (
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic [2:0] tx_cfg,
  input wire logic [2:0] rx_cfg,
  input wire logic       tx_video,
  input wire logic       prop_valid,
  input wire logic [2:0] prop_mode,
  input wire logic       rx_ack,
  input wire logic       rx_prop_valid,
  input wire logic       tx_ack
);
  logic both_auto;
  logic rx_only_man;

  // Codes 5-7 count as auto, so only 1-4 are manual
  assign both_auto   = (tx_cfg == 3'h0) && (rx_cfg == 3'h0);
  assign rx_only_man = (rx_cfg inside {[1:4]}) && !(tx_cfg inside {[1:4]});

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  offer_hold_a: assert property (prop_valid && !rx_ack |=>
    prop_valid && $stable(prop_mode)) else $error("offer dropped early");
  ack_follow_a: assert property ($rose(prop_valid) |=> rx_ack)
    else $error("receiver ack missing");
  rx_ack_pulse_a: assert property (rx_ack |=> !rx_ack)
    else $error("receiver ack too long");
  rx_offer_ack_a: assert property ($rose(rx_prop_valid) |=> tx_ack)
    else $error("transmitter ack missing");
  tx_ack_pulse_a: assert property (tx_ack |=> !tx_ack)
    else $error("transmitter ack too long");
  auto_no_reach_a: assert property (prop_valid && both_auto |->
    prop_mode != 3'h2) else $error("long reach offered in auto");
  auto_video_a: assert property ($rose(prop_valid) && both_auto &&
    tx_video |-> prop_mode == 3'h1) else $error("video without full");
  rx_init_a: assert property ($rose(rx_prop_valid) |-> rx_only_man)
    else $error("receiver initiated wrongly");
  tx_quiet_a: assert property ($rose(prop_valid) |-> !rx_only_man)
    else $error("auto transmitter initiated");
endmodule // tplm_link_properties

// [sim/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import tplm_pkg::*;
  logic       clock_in;
  logic       rst_in;
  logic [2:0] tx_cfg;
  logic [2:0] rx_cfg;
  logic       video;
  logic       lp_eth;
  logic [2:0] tx_mode;
  logic [2:0] rx_mode;
  logic [3:0] tx_ch;
  logic [3:0] rx_ch;
  logic       tx_busy;
  logic       rx_busy;
  int         n_fail;
  int         check_count;

  tplm_link_if link ();
  tplm_tx i_tplm_tx (.clock_in(clock_in), .rst_in(rst_in),
    .cfg_mode_in(tx_cfg), .video_in(video), .lp_eth_in(lp_eth),
    .link(link), .link_mode_out(tx_mode), .chan_en_out(tx_ch),
    .busy_out(tx_busy));
  tplm_rx i_tplm_rx (.clock_in(clock_in), .rst_in(rst_in),
    .cfg_mode_in(rx_cfg), .link(link), .link_mode_out(rx_mode),
    .chan_en_out(rx_ch), .busy_out(rx_busy));
  tplm_link_properties i_tplm_link_properties (.clock_in(clock_in),
    .rst_in(rst_in), .tx_cfg(link.tx_cfg), .rx_cfg(link.rx_cfg),
    .tx_video(link.tx_video), .prop_valid(link.prop_valid),
    .prop_mode(link.prop_mode), .rx_ack(link.rx_ack),
    .rx_prop_valid(link.rx_prop_valid), .tx_ack(link.tx_ack));

  // 25 ns clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Channels {video,audio,eth,serial} each mode should carry
  function automatic logic [3:0] ch_of(input logic [2:0] m);
    case (m)
      3'h1, 3'h2: ch_of = 4'hF;
      3'h4: ch_of = 4'h3;
      default: ch_of = 4'h1;
    endcase
  endfunction

  // Set both ends, wait for the link to settle, then check both ends
  task automatic run(input logic [2:0] t, r, input logic v, e,
                     input logic [2:0] m);
    int i;
    @(posedge clock_in);
    tx_cfg <= t;
    rx_cfg <= r;
    video  <= v;
    lp_eth <= e;
    for (i = 0; i < 30; i++) begin
      @(posedge clock_in);
      #1;
      if (tx_mode === m && rx_mode === m && !tx_busy && !rx_busy) break;
    end
    `CHK(tx_mode, m)
    `CHK(rx_mode, m)
    `CHK(tx_ch, ch_of(m))
    `CHK(rx_ch, ch_of(m))
  endtask

  task automatic summarize;
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang well beyond the eleven short negotiations
  initial begin
    repeat (5000) @(posedge clock_in);
    n_fail++;
    summarize();
  end

  initial begin
    {tx_cfg, rx_cfg, video, lp_eth} = '0;
    rst_in = 1'b1;
    repeat (10) @(posedge clock_in);
    #1;
    `CHK({tx_mode, rx_mode, tx_busy, rx_busy}, 8'h6C)
    rst_in <= 1'b0;
    run(3'h0, 3'h0, 1'b1, 1'b0, 3'h1);
    run(3'h0, 3'h0, 1'b0, 1'b1, 3'h4);
    run(3'h0, 3'h0, 1'b0, 1'b0, 3'h3);
    run(3'h1, 3'h2, 1'b1, 1'b0, 3'h2);
    run(3'h2, 3'h0, 1'b1, 1'b0, 3'h2);
    run(3'h0, 3'h1, 1'b0, 1'b0, 3'h1);
    run(3'h0, 3'h2, 1'b1, 1'b0, 3'h2);
    run(3'h4, 3'h1, 1'b1, 1'b0, 3'h4);
    run(3'h1, 3'h3, 1'b1, 1'b0, 3'h3);
    run(3'h0, 3'h4, 1'b1, 1'b0, 3'h4);
    run(3'h7, 3'h0, 1'b1, 1'b0, 3'h1);
    summarize();
  end
endmodule // tb_top
